// ===== verilog/alarm_supervisor_defines.vh
// Constants for the overload and alarm supervisor.
// Assumes inclusion by bare name from the design files.
`ifndef ALARM_SUPERVISOR_DEFINES_VH
`define ALARM_SUPERVISOR_DEFINES_VH
`define CLK_HZ 25000000
`define TICK_US 1000
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`define BLINK_MS 250
`define BLINK_CYCLES ((`CLK_HZ / 1000) * `BLINK_MS)
`define CODE_DEVIATION 8'h10
`define BLINKS_DEVIATION 4'h4
`define CODE_OVERLOAD 8'h30
`define BLINKS_OVERLOAD 4'h2
`define HIST_DEPTH 10
`endif

// ===== verilog/alarm_history.v
// Ten-entry newest-first alarm code history held in flip-flops.
// Assumes the surrounding logic supplies one-cycle push and erase pulses.
`timescale 1ns/10ps
`default_nettype none
`include "alarm_supervisor_defines.vh"
module alarm_history #(
   parameter DEPTH = `HIST_DEPTH,
   parameter CODE_W = 8
) (
   input wire clk,
   input wire nrst,
   input wire push,
   input wire [CODE_W-1:0] push_code,
   input wire erase,
   input wire [3:0] rd_index,
   output reg [CODE_W-1:0] rd_code
);
   reg [CODE_W-1:0] entry_q [0:DEPTH-1];
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_entry
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               entry_q[i] <= {CODE_W{1'b0}};
            end else if (push) begin
               // Shift older entries down; the last one falls off
               // A code raised with an erase survives as the only entry
               if (i == 0) begin
                  entry_q[i] <= push_code;
               end else if (erase) begin
                  entry_q[i] <= {CODE_W{1'b0}};
               end else begin
                  entry_q[i] <= entry_q[(i == 0) ? 0 : i - 1];
               end
            end else if (erase) begin
               entry_q[i] <= {CODE_W{1'b0}};
            end
         end
      end
   endgenerate
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_code <= {CODE_W{1'b0}};
      end else if (rd_index < DEPTH) begin
         rd_code <= entry_q[rd_index];
      end else begin
         rd_code <= {CODE_W{1'b0}};
      end
   end
endmodule
`default_nettype wire

// ===== verilog/alarm_overload_supervisor.v
// Overload integrator, alarm latch, lamp blinker and alarm history.
// Assumes synchronous inputs on one 25 MHz clock; power cycle is nrst.
// Overview of operation
// - Overload sets indicator and counts integrator up
// - Integrator reaching threshold raises overload alarm
// - Release clears indicator, integrator decays gradually
// - Recurring overload resumes from remaining value
// - Alarm drives outputs and stops motor
// - Pending alarm blinks lamp red, count identifies cause
// - Clear input acts on rising edge only
// - Serial reset command clears; power cycle always clears
// - Some alarms clear only by power cycle
// - Position error clears on preset done
// - Keep last ten codes, newest first
// - History read and erase by serial commands
// - Deviation alarm code 10h, four blinks, clearable
`timescale 1ns/10ps
`default_nettype none
`include "alarm_supervisor_defines.vh"
module alarm_overload_supervisor #(
   parameter INT_W = 16,
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter BLINK_CYCLES = `BLINK_CYCLES
) (
   input wire clk,
   input wire nrst,
   input wire overload_cond,
   input wire [INT_W-1:0] overload_threshold,
   input wire deviation_exceeded,
   input wire ext_alarm,
   input wire [7:0] ext_alarm_code,
   input wire [3:0] ext_alarm_blinks,
   input wire ext_alarm_power_only,
   input wire abs_pos_error,
   input wire preset_done,
   input wire alarm_clear_input,
   input wire serial_alarm_reset,
   input wire serial_hist_erase,
   input wire [3:0] hist_rd_index,
   output wire [7:0] hist_rd_code,
   output reg overload_indicator,
   output reg [INT_W-1:0] overload_count,
   output reg alarm_out_active,
   output reg alarm_out_complement,
   output reg motor_stop,
   output reg status_lamp_red,
   output reg [7:0] alarm_code
);
   localparam ST_IDLE = 2'd0;
   localparam ST_ON = 2'd1;
   localparam ST_OFF = 2'd2;
   localparam ST_GAP = 2'd3;
   localparam [INT_W-1:0] INT_MAX = {INT_W{1'b1}};

   reg [31:0] tick_cnt_q;
   reg tick_q;
   reg clr_in_q;
   reg alarm_q;
   reg power_only_q;
   reg abs_alarm_q;
   reg [3:0] blinks_q;
   reg [1:0] lamp_st_q;
   reg [3:0] blink_idx_q;
   reg [31:0] lamp_cnt_q;
   reg push_q;
   wire clr_edge;
   wire soft_clear;
   wire ovl_hit;
   wire new_alarm;
   wire lamp_step;

   // Millisecond tick for the integrator
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_CYCLES - 1) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overload_indicator <= 1'b0;
         overload_count <= {INT_W{1'b0}};
      end else begin
         overload_indicator <= overload_cond;
         if (tick_q) begin
            if (overload_cond) begin
               if (overload_count != INT_MAX) begin
                  overload_count <= overload_count + 1'b1;
               end
            end else if (overload_count != {INT_W{1'b0}}) begin
               overload_count <= overload_count - 1'b1;
            end
         end
      end
   end

   assign ovl_hit = (overload_count >= overload_threshold);
   assign clr_edge = alarm_clear_input & ~clr_in_q;
   assign soft_clear = (clr_edge | serial_alarm_reset) & ~power_only_q;
   assign new_alarm = ~alarm_q & (ovl_hit | deviation_exceeded | ext_alarm | abs_pos_error);

   // First alarm wins and is latched until cleared
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clr_in_q <= 1'b0;
         alarm_q <= 1'b0;
         power_only_q <= 1'b0;
         abs_alarm_q <= 1'b0;
         alarm_code <= 8'h00;
         blinks_q <= 4'h0;
         push_q <= 1'b0;
      end else begin
         clr_in_q <= alarm_clear_input;
         push_q <= new_alarm;
         if (new_alarm) begin
            alarm_q <= 1'b1;
            abs_alarm_q <= 1'b0;
            power_only_q <= 1'b0;
            if (ovl_hit) begin
               alarm_code <= `CODE_OVERLOAD;
               blinks_q <= `BLINKS_OVERLOAD;
            end else if (deviation_exceeded) begin
               alarm_code <= `CODE_DEVIATION;
               blinks_q <= `BLINKS_DEVIATION;
            end else begin
               alarm_code <= ext_alarm_code;
               blinks_q <= ext_alarm_blinks;
               power_only_q <= ext_alarm & ext_alarm_power_only;
               abs_alarm_q <= ~ext_alarm;
            end
         end else if (alarm_q & (soft_clear | (abs_alarm_q & preset_done))) begin
            alarm_q <= 1'b0;
            abs_alarm_q <= 1'b0;
         end
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarm_out_active <= 1'b0;
         alarm_out_complement <= 1'b1;
         motor_stop <= 1'b0;
      end else begin
         alarm_out_active <= alarm_q;
         alarm_out_complement <= ~alarm_q;
         motor_stop <= alarm_q;
      end
   end

   // Blink N times, then a long gap of one full on-off blink period
   assign lamp_step = (lamp_cnt_q == BLINK_CYCLES - 1);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lamp_st_q <= ST_IDLE;
         lamp_cnt_q <= 32'h0000_0000;
         blink_idx_q <= 4'h0;
         status_lamp_red <= 1'b0;
      end else if (!alarm_q) begin
         lamp_st_q <= ST_IDLE;
         lamp_cnt_q <= 32'h0000_0000;
         blink_idx_q <= 4'h0;
         status_lamp_red <= 1'b0;
      end else begin
         lamp_cnt_q <= lamp_step ? 32'h0000_0000 : lamp_cnt_q + 32'h0000_0001;
         case (lamp_st_q)
            ST_IDLE: begin
               lamp_st_q <= ST_ON;
               lamp_cnt_q <= 32'h0000_0000;
               blink_idx_q <= 4'h1;
               status_lamp_red <= 1'b1;
            end
            ST_ON: begin
               if (lamp_step) begin
                  lamp_st_q <= ST_OFF;
                  status_lamp_red <= 1'b0;
               end
            end
            ST_OFF: begin
               if (lamp_step) begin
                  if (blink_idx_q >= blinks_q) begin
                     lamp_st_q <= ST_GAP;
                     blink_idx_q <= 4'h0;
                  end else begin
                     lamp_st_q <= ST_ON;
                     blink_idx_q <= blink_idx_q + 4'h1;
                     status_lamp_red <= 1'b1;
                  end
               end
            end
            default: begin
               if (lamp_step) begin
                  if (blink_idx_q == 4'h1) begin
                     lamp_st_q <= ST_IDLE;
                  end else begin
                     blink_idx_q <= 4'h1;
                  end
               end
            end
         endcase
      end
   end

   alarm_history #(
      .DEPTH(`HIST_DEPTH),
      .CODE_W(8)
   ) u_history (
      .clk(clk),
      .nrst(nrst),
      .push(push_q),
      .push_code(alarm_code),
      .erase(serial_hist_erase),
      .rd_index(hist_rd_index),
      .rd_code(hist_rd_code)
   );
endmodule
`default_nettype wire

// ===== bench/sup_chk.sv
// Checker of the alarm supervisor outputs.
// Assumes binding to the top module, one clock.
`timescale 1ns/10ps
`default_nettype none
module sup_chk #(parameter INT_W = 16) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic overload_cond,
   input wire logic [INT_W-1:0] overload_threshold,
   input wire logic overload_indicator,
   input wire logic [INT_W-1:0] overload_count,
   input wire logic alarm_out_active,
   input wire logic alarm_out_complement,
   input wire logic motor_stop,
   input wire logic status_lamp_red
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_ind_rise: assert property ($rose(overload_cond) |=> overload_indicator)
      else $error("indicator late");
   chk_alm_pair: assert property (alarm_out_active ^ alarm_out_complement)
      else $error("alarm pair");
   chk_alm_stop: assert property (motor_stop == alarm_out_active)
      else $error("motor stop");
   chk_cnt_step: assert property (!$stable(overload_count) |->
      overload_count - $past(overload_count) inside {1, -1})
      else $error("count jump");
   chk_up_cause: assert property (overload_count > $past(overload_count) |->
      $past(overload_cond) || $past(overload_cond, 2))
      else $error("count up idle");
   chk_dn_cause: assert property (overload_count < $past(overload_count) |->
      !$past(overload_cond) || !$past(overload_cond, 2))
      else $error("count down busy");
   chk_ovl_raise: assert property (overload_cond && overload_indicator &&
      overload_count >= overload_threshold |-> ##[1:3] alarm_out_active)
      else $error("no overload alarm");
   chk_lamp_dark: assert property (!alarm_out_active ##1 !alarm_out_active
      ##1 !alarm_out_active |-> !status_lamp_red)
      else $error("lamp lit");
endmodule
bind alarm_overload_supervisor sup_chk #(.INT_W(INT_W)) u_chk (.clk, .nrst, .overload_cond,
   .overload_threshold, .overload_indicator, .overload_count, .alarm_out_active,
   .alarm_out_complement, .motor_stop, .status_lamp_red);
`default_nettype wire

// ===== bench/host_model.sv
// Host model driving the clear input and serial commands.
// Assumes its tasks are called just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk,
   output logic alarm_clear_input,
   output logic serial_alarm_reset,
   output logic serial_hist_erase
);
   initial {alarm_clear_input, serial_alarm_reset, serial_hist_erase} = 3'h0;
   // Caller removes the cause before raising the level
   task automatic clr(input logic v);
      @(posedge clk);
      #1 alarm_clear_input = v;
   endtask
   task automatic ser(input logic erase);
      @(posedge clk);
      #1 {serial_hist_erase, serial_alarm_reset} = {erase, !erase};
      @(posedge clk);
      #1 {serial_hist_erase, serial_alarm_reset} = 2'h0;
   endtask
endmodule
`default_nettype wire

// ===== bench/alarm_overload_supervisor_tb_top.sv
// Bench of the alarm supervisor, ticks and blinks of 4 clocks.
// Assumes host_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module alarm_overload_supervisor_tb_top;
   logic clk = 1'h0, nrst = 1'h0, oc = 1'h0, dev = 1'h0, ext = 1'h0, pwo = 1'h0;
   logic ape = 1'h0, pre = 1'h0, ind, act, cmp, stp, lamp, clr, srst, sers, p;
   logic [15:0] thr = 16'h0005, cnt, r, lfsr_q = 16'h005D;
   logic [7:0] ec = 8'h01, code, hc, hq[$];
   logic [3:0] idx = 4'h0, eb = 4'h3;
   int n_mismatch = 0, total_checks = 0, k, t, n, j;
   initial forever #20 clk = ~clk;
   host_model host (.clk(clk), .alarm_clear_input(clr), .serial_alarm_reset(srst),
      .serial_hist_erase(sers));
   alarm_overload_supervisor #(.TICK_CYCLES(4), .BLINK_CYCLES(4)) DUT (.clk(clk),
      .nrst(nrst), .overload_cond(oc), .overload_threshold(thr), .deviation_exceeded(dev),
      .ext_alarm(ext), .ext_alarm_code(ec), .ext_alarm_blinks(eb),
      .ext_alarm_power_only(pwo), .abs_pos_error(ape), .preset_done(pre),
      .alarm_clear_input(clr), .serial_alarm_reset(srst), .serial_hist_erase(sers),
      .hist_rd_index(idx), .hist_rd_code(hc), .overload_indicator(ind),
      .overload_count(cnt), .alarm_out_active(act), .alarm_out_complement(cmp),
      .motor_stop(stp), .status_lamp_red(lamp), .alarm_code(code));
   task automatic chk(input string s, input logic [15:0] v, input logic [15:0] e);
      total_checks++;
      if (v !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", s, e, v);
      end
   endtask
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction
   // Deviation has its own fixed code, external and position error causes report the input code
   function automatic logic [7:0] cause_code(input logic d, input logic [7:0] c);
      return d ? 8'h10 : c;
   endfunction
   // One lamp sequence: b blinks of 8 clocks, an 8 clock gap and one idle clock
   function automatic int blink_period(input int b);
      return 8 * b + 9;
   endfunction
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wait_alarm(output int c);
      for (c = 0; act !== 1'h1 && c < 500; c++) cyc(1);
   endtask
   // Counts lamp rises over exactly two full sequences
   task automatic blinks(input int b);
      n = 0;
      p = lamp;
      repeat (2 * blink_period(b)) begin
         cyc(1);
         n += (lamp === 1'h1 && !p);
         p = lamp;
      end
      chk("blinks", 16'(n), 16'(2 * b));
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // All tests take well under 3000 clocks
   initial begin
      cyc(10000);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      cyc(8);
      nrst = 1'h1;
      cyc(1);
      thr = 16'(rnd() % 8 + 4);
      oc = 1'h1;
      wait_alarm(t);
      chk("count", cnt, thr);
      chk("code", 16'(code), 16'h0030);
      chk("outs", 16'({ind, act, cmp, stp}), 16'h000D);
      oc = 1'h0;
      cyc(8);
      chk("decay", 16'(cnt < thr && cnt != 16'h0000 && !ind), 16'h0001);
      host.clr(1'h1);
      cyc(3);
      chk("clear", 16'(act), 16'h0000);
      oc = 1'h1;
      wait_alarm(k);
      chk("sooner", 16'(k < t), 16'h0001);
      oc = 1'h0;
      blinks(2);
      chk("hist", 16'(hc), 16'h0030);
      host.ser(1'h0);
      cyc(3);
      chk("serial", 16'({act, cnt == 16'h0000}), 16'h0001);
      $display("test overload done");
      dev = 1'h1;
      wait_alarm(k);
      chk("dev code", 16'(code), 16'h0010);
      blinks(4);
      dev = 1'h0;
      cyc(3);
      chk("held clear", 16'(act), 16'h0001);
      host.clr(1'h0);
      host.clr(1'h1);
      cyc(3);
      chk("dev clear", 16'(act), 16'h0000);
      $display("test deviation done");
      // First pass always locks; the second draws the lock at random
      for (j = 0; j < 2; j++) begin
         ec = 8'(rnd()) | 8'h01;
         r = rnd();
         eb = 4'(r[6:5]) + 4'h1;
         pwo = r[4] | (j == 0);
         ext = 1'h1;
         wait_alarm(k);
         chk("ext code", 16'(code), 16'(ec));
         blinks(int'(eb));
         ext = 1'h0;
         host.ser(1'h0);
         host.clr(1'h0);
         host.clr(1'h1);
         cyc(3);
         chk("locked", 16'(act), 16'(pwo));
         nrst = 1'h0;
         cyc(2);
         {nrst, pwo} = 2'h2;
         cyc(1);
         chk("power", 16'({act, cmp}), 16'h0001);
      end
      $display("test power done");
      for (k = 0; k < 11; k++) begin
         ec = 8'(rnd()) | 8'h01;
         r = rnd();
         dev = (r[1:0] == 2'h1);
         ext = (r[1:0] == 2'h2);
         ape = (r[1] == r[0]);
         hq.push_front(cause_code(dev, ec));
         wait_alarm(t);
         chk("cause", 16'(code), 16'(hq[0]));
         {dev, ext, ape} = 3'h0;
         pre = r[2] | (r[1] == r[0]);
         cyc(1);
         pre = 1'h0;
         cyc(3);
         chk("preset", 16'(act), 16'(r[1] != r[0]));
         host.clr(1'h0);
         host.clr(1'h1);
         cyc(3);
         chk("cleared", 16'(act), 16'h0000);
      end
      for (k = 0; k < 10; k++) begin
         idx = 4'(k);
         cyc(2);
         chk("order", 16'(hc), 16'(hq[k]));
      end
      host.ser(1'h1);
      idx = 4'h0;
      cyc(2);
      chk("erase", 16'(hc), 16'h0000);
      $display("test history done");
      wrap_up();
   end
endmodule
`default_nettype wire
